// ### core/adc_seq_params.svh
// constants of the serial converter sequencer
// assumes one system clock domain; serial pins are asynchronous to it
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

`define RES_BITS        8
`define ADDR_BITS       3
`define CNT_BITS        4
`define CONV_CYCLES     6'd36
`define CONV_LAST       6'd35
`define SAR_CYCLES      6'd32
`define SAR_STEP_LOG2   2
`define FILTER_CYCLES   2'd3
`define ADDR_EDGES      4'd3
`define SAMPLE_EDGE     4'd4
`define LAST_EDGE       4'd8
`define SELF_TEST_ADDR  3'h5
`define CODE_MID        8'h80
`define CODE_ZERO       8'h00
`define FIFO_DEPTH      2'd2

`endif

// ### core/adc_seq_pkg.sv
// types shared by the serial converter sequencer
// assumes adc_seq_params.svh is compiled alongside
package adc_seq_pkg;
  typedef enum logic [0:0] {
    st_idle,
    st_conv
  } conv_state_t;
endpackage

// ### core/serial_adc_sequencer.sv
// serial access and successive-approximation control of an 8-bit converter
// assumes cs_n, io_clk and addr_in arrive asynchronously; comp_hi is the
// analog comparator output settled within one sys_clk of dac_code
`include "adc_seq_params.svh"

module serial_adc_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic                    cs_n,
  input  wire logic                    io_clk,
  input  wire logic                    addr_in,
  input  wire logic                    comp_hi,
  output logic                         data_out,
  output logic                         data_out_oe,
  output logic                         eoc,
  output logic [`ADDR_BITS-1:0]        mux_sel,
  output logic                         self_test_sel,
  output logic                         sample_en,
  output logic [`RES_BITS-1:0]         dac_code
);

  // synchronisers: first stage feeds only the second
  logic [2:0] cs_sync_reg;
  logic [2:0] io_sync_reg;
  logic [1:0] ad_sync_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cs_sync_reg <= 3'h7;
      io_sync_reg <= 3'h0;
      ad_sync_reg <= 2'h0;
    end
    else
    begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
      io_sync_reg <= {io_sync_reg[1:0], io_clk};
      ad_sync_reg <= {ad_sync_reg[0], addr_in};
    end
  end

  logic cs_edge;
  logic io_rise;
  logic io_fall;
  logic ad_bit;
  assign cs_edge = cs_sync_reg[2] ^ cs_sync_reg[1];
  assign io_rise = io_sync_reg[1] & ~io_sync_reg[2];
  assign io_fall = ~io_sync_reg[1] & io_sync_reg[2];
  assign ad_bit  = ad_sync_reg[1];

  conv_state_t                 state_reg,   state_next;
  logic [1:0]                  filt_reg,    filt_next;
  logic                        sel_reg,     sel_next;
  logic [`CNT_BITS-1:0]        fall_reg,    fall_next;
  logic [`CNT_BITS-1:0]        rise_reg,    rise_next;
  logic [`ADDR_BITS-1:0]       addr_reg,    addr_next;
  logic [`ADDR_BITS-1:0]       mux_reg,     mux_next;
  logic [`RES_BITS-1:0]        shift_reg,   shift_next;
  logic [`RES_BITS-1:0]        result_reg,  result_next;
  logic [`RES_BITS-1:0]        sar_reg,     sar_next;
  logic [5:0]                  cyc_reg,     cyc_next;
  logic                        dout_reg,    dout_next;
  logic                        oe_reg,      oe_next;
  logic                        eoc_reg,     eoc_next;
  logic                        samp_reg,    samp_next;
  logic [`RES_BITS-1:0]        dac_reg,     dac_next;
  logic                        st_reg,      st_next;
  // two-entry result buffer between converter and serial output
  logic [`RES_BITS-1:0]        fifo_mem [2];
  logic [`RES_BITS-1:0]        fifo_mem_next [2];
  logic                        wr_ptr_reg,  wr_ptr_next;
  logic                        rd_ptr_reg,  rd_ptr_next;
  logic [1:0]                  fcnt_reg,    fcnt_next;

  logic live;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [2:0] bit_idx;
  logic [`RES_BITS-1:0] trial;

  always_comb
  begin
    state_next    = state_reg;
    filt_next     = filt_reg;
    sel_next      = sel_reg;
    fall_next     = fall_reg;
    rise_next     = rise_reg;
    addr_next     = addr_reg;
    mux_next      = mux_reg;
    shift_next    = shift_reg;
    result_next   = result_reg;
    sar_next      = sar_reg;
    cyc_next      = cyc_reg;
    dout_next     = dout_reg;
    oe_next       = oe_reg;
    eoc_next      = eoc_reg;
    samp_next     = samp_reg;
    fifo_mem_next = fifo_mem;
    wr_ptr_next   = wr_ptr_reg;
    rd_ptr_next   = rd_ptr_reg;
    bit_idx       = 3'(7 - cyc_reg[5:`SAR_STEP_LOG2]);
    trial         = sar_reg;
    push_valid    = 1'b0;
    push_ready    = (fcnt_reg != `FIFO_DEPTH);

    // select filter: a change restarts the quiet window
    if (cs_edge)
      filt_next = `FILTER_CYCLES;
    else if (filt_reg != 2'd0)
    begin
      filt_next = filt_reg - 2'd1;
      if (filt_reg == 2'd1)
      begin
        sel_next  = ~cs_sync_reg[2];
        fall_next = 4'd0;
        rise_next = 4'd0;
        if (~cs_sync_reg[2])
        begin
          state_next = st_idle;   // recognised select aborts conversion
          samp_next  = 1'b0;
          shift_next = result_reg;
          dout_next  = result_reg[`RES_BITS-1];
          oe_next    = 1'b1;
        end
        else
          oe_next = 1'b0;
      end
    end

    live = sel_reg && (filt_reg == 2'd0) && !cs_edge;
    if (live && io_rise && rise_reg < `ADDR_EDGES)
    begin
      addr_next = {addr_reg[`ADDR_BITS-2:0], ad_bit};
      rise_next = rise_reg + 4'd1;
    end

    if (live && io_fall)
    begin
      fall_next = (fall_reg == `LAST_EDGE) ? 4'd1 : fall_reg + 4'd1;
      if (fall_next == `LAST_EDGE)
      begin
        // hold begins; host sets this instant by its eighth pulse
        samp_next  = 1'b0;
        rise_next  = 4'd0;
        mux_next   = addr_reg;
        state_next = st_conv;
        cyc_next   = 6'd0;
        sar_next   = `CODE_ZERO;
        eoc_next   = 1'b0;
        shift_next = result_reg;
        dout_next  = result_reg[`RES_BITS-1];
      end
      else
      begin
        shift_next = {shift_reg[`RES_BITS-2:0], 1'b0};
        dout_next  = shift_reg[`RES_BITS-2];
        if (fall_next == `SAMPLE_EDGE)
        begin
          mux_next  = addr_reg;
          samp_next = 1'b1;
        end
      end
    end

    // successive approximation: 4 cycles per bit, 36 cycles in all
    unique case (state_reg)
      st_idle: ;
      st_conv:
      begin
        if (cyc_reg < `SAR_CYCLES)
        begin
          trial = sar_reg | (`CODE_MID >> (7 - bit_idx));
          if (cyc_reg[1:0] == 2'd3)
            sar_next = comp_hi ? trial : sar_reg;
        end
        if (cyc_reg == `CONV_LAST)
        begin
          push_valid = 1'b1;
          if (push_ready)
          begin
            state_next = st_idle;
            eoc_next   = 1'b1;
          end
        end
        else
          cyc_next = cyc_reg + 6'd1;
      end
    endcase

    // dac trial code is registered so the comparator sees a steady level
    dac_next = (state_reg == st_conv) ? trial : sar_reg;
    st_next  = (mux_next >= `SELF_TEST_ADDR);
    if (push_valid && push_ready)
    begin
      fifo_mem_next[wr_ptr_reg] = sar_reg;
      wr_ptr_next = ~wr_ptr_reg;
    end

    // drain while deselected or while fall_reg is 0 or 8, so the word holds from the first to the eighth falling edge
    pop_valid = (fcnt_reg != 2'd0);
    pop_ready = !sel_reg || fall_reg == 4'd0 || fall_reg == `LAST_EDGE;
    if (pop_valid && pop_ready && !(live && io_fall))
    begin
      result_next = fifo_mem[rd_ptr_reg];
      rd_ptr_next = ~rd_ptr_reg;
      if (sel_next)
      begin
        shift_next = fifo_mem[rd_ptr_reg];
        dout_next  = fifo_mem[rd_ptr_reg][`RES_BITS-1];
      end
    end
    fcnt_next = fcnt_reg
              + {1'b0, push_valid && push_ready}
              - {1'b0, pop_valid && pop_ready && !(live && io_fall)};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg   <= st_idle;
      filt_reg    <= 2'd0;
      sel_reg     <= 1'b0;
      fall_reg    <= 4'd0;
      rise_reg    <= 4'd0;
      addr_reg    <= 3'h0;
      mux_reg     <= 3'h0;
      shift_reg   <= `CODE_ZERO;
      result_reg  <= `CODE_ZERO;
      sar_reg     <= `CODE_ZERO;
      cyc_reg     <= 6'd0;
      dout_reg    <= 1'b0;
      oe_reg      <= 1'b0;
      eoc_reg     <= 1'b1;
      samp_reg    <= 1'b0;
      dac_reg     <= `CODE_ZERO;
      st_reg      <= 1'b0;
      fifo_mem[0] <= `CODE_ZERO;
      fifo_mem[1] <= `CODE_ZERO;
      wr_ptr_reg  <= 1'b0;
      rd_ptr_reg  <= 1'b0;
      fcnt_reg    <= 2'd0;
    end
    else
    begin
      state_reg   <= state_next;
      filt_reg    <= filt_next;
      sel_reg     <= sel_next;
      fall_reg    <= fall_next;
      rise_reg    <= rise_next;
      addr_reg    <= addr_next;
      mux_reg     <= mux_next;
      shift_reg   <= shift_next;
      result_reg  <= result_next;
      sar_reg     <= sar_next;
      cyc_reg     <= cyc_next;
      dout_reg    <= dout_next;
      oe_reg      <= oe_next;
      eoc_reg     <= eoc_next;
      samp_reg    <= samp_next;
      dac_reg     <= dac_next;
      st_reg      <= st_next;
      fifo_mem    <= fifo_mem_next;
      wr_ptr_reg  <= wr_ptr_next;
      rd_ptr_reg  <= rd_ptr_next;
      fcnt_reg    <= fcnt_next;
    end
  end

  assign data_out      = dout_reg;
  assign data_out_oe   = oe_reg;
  assign eoc           = eoc_reg;
  assign mux_sel       = mux_reg;
  assign self_test_sel = st_reg;
  assign sample_en     = samp_reg;
  assign dac_code      = dac_reg;

endmodule // serial_adc_sequencer

// ### sim/serial_adc_sequencer_monitor.sv
// port checker of the serial converter sequencer
// assumes binding into serial_adc_sequencer; one sys_clk domain
module serial_adc_sequencer_monitor (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       cs_n,
  input wire logic       data_out_oe,
  input wire logic       eoc,
  input wire logic [2:0] mux_sel,
  input wire logic       self_test_sel,
  input wire logic       sample_en,
  input wire logic [7:0] dac_code
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] low_cnt_reg;
  logic [6:0] low_cnt_next;
  // cycles that eoc has been low
  always_comb low_cnt_next = (reset || eoc) ? 7'h00 : low_cnt_reg + 7'h01;
  always_ff @(posedge sys_clk) low_cnt_reg <= low_cnt_next;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_sel_held; (!cs_n)[*8]; endsequence
  sequence s_desel; cs_n[*8]; endsequence
  property p_oe_on; s_sel_held |=> data_out_oe; endproperty
  property p_oe_off; s_desel |=> !data_out_oe; endproperty
  property p_eoc_fall; $fell(eoc) |-> $fell(sample_en); endproperty
  property p_conv_len; $rose(eoc) |-> low_cnt_reg == 7'h24; endproperty
  property p_mux_idle; $changed(mux_sel) |-> data_out_oe; endproperty
  property p_self_test;
    $stable(mux_sel) |-> self_test_sel == (mux_sel >= 3'h5);
  endproperty
  property p_sample_sel; sample_en |-> data_out_oe; endproperty
  property p_reset;
    disable iff (1'b0)
    reset |=> eoc && !data_out_oe && !sample_en && dac_code == 8'h00;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output not enabled while selected");
  a_oe_off: assert property (p_oe_off)
    else $error("output enabled while deselected");
  a_eoc_fall: assert property (p_eoc_fall)
    else $error("eoc fall not at end of sampling");
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  a_mux_idle: assert property (p_mux_idle)
    else $error("channel changed while deselected");
  a_self_test: assert property (p_self_test)
    else $error("self-test select wrong");
  a_sample_sel: assert property (p_sample_sel)
    else $error("sampling while deselected");
  a_reset: assert property (p_reset)
    else $error("reset values wrong");
endmodule // serial_adc_sequencer_monitor

bind serial_adc_sequencer serial_adc_sequencer_monitor mon (
  .sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .data_out_oe(data_out_oe),
  .eoc(eoc), .mux_sel(mux_sel), .self_test_sel(self_test_sel),
  .sample_en(sample_en), .dac_code(dac_code));

// ### sim/adc_host_model.sv
// host side of the serial link: select, shift clock, address
// assumes pins asynchronous to sys_clk; shift clock period 125 ns
module adc_host_model (
  output logic      cs_n,
  output logic      io_clk,
  output logic      addr_in,
  input  wire logic data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    cs_n = 1'b1;
    io_clk = 1'b0;
    addr_in = 1'b0;
  end
  // eight pulses; result bits read on rising edges
  task automatic frame(input logic [2:0] addr, input int hold_ns,
                       output logic [7:0] rd);
    if (cs_n)
    begin
      cs_n = 1'b0;
      #60; // select setup before shifting
    end
    for (int i = 0; i < 8; i++)
    begin
      addr_in = (i < 3) ? addr[2 - i] : ~addr_in; // msb first
      #62.5 io_clk = 1'b1;
      rd[7 - i] = data_out;
      // eighth pulse may be held high to end sampling late
      #(62.5 + ((i == 7) ? hold_ns : 0)) io_clk = 1'b0;
    end
  endtask
  task automatic select_cs();
    cs_n = 1'b0;
  endtask
  // shift clock stays low after a frame until the next
  task automatic release_cs();
    #20 cs_n = 1'b1;
    #60;
  endtask
  task automatic stray_pulses();
    repeat (4)
    begin
      #62.5 io_clk = 1'b1;
      addr_in = ~addr_in;
      #62.5 io_clk = 1'b0;
    end
  endtask
endmodule // adc_host_model

// ### sim/serial_adc_sequencer_tb.sv
// self-checking bench of the serial converter sequencer
// assumes adc_host_model and the bound port checker
module serial_adc_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk, reset, comp_hi, cs_n, io_clk, addr_in;
  logic       data_out, data_out_oe, eoc, self_test_sel, sample_en;
  logic [2:0] mux_sel;
  logic [7:0] dac_code;
  int         n_fail, total_checks, vin2;
  adc_host_model host (.cs_n(cs_n), .io_clk(io_clk), .addr_in(addr_in),
                       .data_out(data_out));
  serial_adc_sequencer dut (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n),
    .io_clk(io_clk), .addr_in(addr_in), .comp_hi(comp_hi),
    .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
    .mux_sel(mux_sel), .self_test_sel(self_test_sel),
    .sample_en(sample_en), .dac_code(dac_code));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // comparator: input held at twice the code scale, half a step off
  always @(negedge sys_clk) comp_hi <= vin2 > 2 * int'(dac_code);
  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_eoc();
    int k;
    k = 0;
    while (eoc !== 1'b1 && k < 200)
    begin
      @(negedge sys_clk);
      k++;
    end
    if (eoc !== 1'b1)
    begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic t_idle();
    check({eoc, data_out_oe, sample_en, self_test_sel, 1'b0, mux_sel},
          8'h80);
    check(dac_code, 8'h00);
    host.stray_pulses();
    check({eoc, data_out_oe, 3'h0, mux_sel}, 8'h80);
    host.select_cs();
    @(negedge sys_clk);
    check({7'h0, data_out_oe}, 8'h00);
    repeat (10) @(negedge sys_clk);
    check({data_out_oe, data_out}, 8'h02);
    host.release_cs();
    check({7'h0, data_out_oe}, 8'h00);
  endtask
  task automatic conv(input int v, input logic [2:0] a, input int h,
                      input logic [7:0] prev, input bit keep);
    logic [7:0] rd;
    vin2 = v;
    host.frame(a, h, rd);
    check(rd, prev);
    repeat (8) @(negedge sys_clk);
    check({eoc, data_out}, {7'h0, prev[7]});
    check({self_test_sel, 4'h0, mux_sel}, {a >= 3'h5, 4'h0, a});
    wait_eoc();
    repeat (4) @(negedge sys_clk);
    if (!keep)
    begin
      host.release_cs();
      check({7'h0, data_out_oe}, 8'h00);
    end
  endtask
  initial
  begin
    reset = 1'b1;
    comp_hi = 1'b0;
    vin2 = 0;
    n_fail = 0;
    total_checks = 0;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    t_idle();
    conv(1000, 3'h3, 0, 8'h00, 1'b0);
    conv(-1, 3'h5, 0, 8'hff, 1'b0);
    conv(331, 3'h7, 500, 8'h00, 1'b1);
    conv(331, 3'h1, 0, 8'ha5, 1'b0);
    conv(0, 3'h2, 0, 8'ha5, 1'b0);
    stop_test();
  end
endmodule // serial_adc_sequencer_tb
